// file: src/dvm_level_ctrl.v
/*
 * dvm_level_ctrl.v: per-channel attenuation, mute, zero-cross and
 * soft-ramp level control with an AHB-Lite register slave.
 * Assumes one hclk domain; frame_clock is an asynchronous pin;
 * zero_cross_a/b are one-cycle pulses from the sample path on hclk.
 */
// Our own choice: the AHB-Lite register port.
`include "dvm_map.vh"
`timescale 1ns/100ps
`default_nettype none

module dvm_level_ctrl (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // AHB-Lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  // sample path
  input wire frame_clock,
  input wire zero_cross_a,
  input wire zero_cross_b,
  input wire mode_event,
  // level and control outputs
  output reg [`DVM_LVL_W-1:0] level_a,
  output reg [`DVM_LVL_W-1:0] level_b,
  output reg silence_indicator_pin_a,
  output reg silence_indicator_pin_b,
  output reg rolloff_select,
  output reg low_power_state,
  output reg host_port_enable
);

  localparam SQ_IDLE = 2'h0;
  localparam SQ_DOWN = 2'h1;
  localparam SQ_UP = 2'h2;
  localparam [7:0] RAMP_RST = `DVM_RST_RAMP;
  localparam [9:0] TMO_LAST = `DVM_ZC_TIMEOUT - 10'h001;

  // stored (host-visible) registers
  reg [7:0] mix_reg;
  reg [7:0] mute_reg;
  reg [7:0] vol_a_reg;
  reg [7:0] vol_b_reg;
  reg [7:0] ramp_reg;
  reg [7:0] misc_reg;
  // applied settings
  reg [7:0] eff_vol_a;
  reg [7:0] eff_vol_b;
  reg [1:0] eff_mode;
  reg eff_up;
  reg eff_dn;
  reg eff_filt;
  reg eff_link;
  reg eff_mute_a;
  reg eff_mute_b;
  // bus data phase
  reg wr_pend;
  reg [7:0] wr_idx;
  // frame clock synchroniser
  reg fc_s1;
  reg fc_s2;
  reg fc_s3;
  reg fc_lvl;
  // sequencer
  reg [1:0] seq_state;
  reg force_mute;
  reg seq_imm;
  // channel state
  reg [`DVM_LVL_W-1:0] cur [0:1];
  reg [9:0] tmo [0:1];

  integer c;
  wire addr_ok = hsel & htrans[1] & hready;
  wire [7:0] a_idx = haddr[9:2];
  wire bus_wr = wr_pend;
  wire tick = (fc_s2 == fc_s3) & fc_s2 & ~fc_lvl;
  wire [7:0] wbyte = hwdata[7:0];
  wire apply = misc_reg[`DVM_HOST_PORT_ENABLE_BIT] & ~misc_reg[`DVM_FREEZE_BIT];

  function [7:0] wmerge;
    input [7:0] mask;
    input [7:0] rst;
    input [7:0] din;
    begin
      wmerge = (din & mask) | (rst & ~mask);
    end
  endfunction

  function [`DVM_LVL_W-1:0] target_of;
    input [7:0] code;
    input mute;
    begin
      if (mute)
        target_of = `DVM_LVL_MUTE;
      else
        target_of = {code, 2'b00};
    end
  endfunction

  // channel B takes A's volume code, but keeps its own mute, when linked
  wire [7:0] code_b = eff_link ? eff_vol_a : eff_vol_b;
  wire [`DVM_LVL_W-1:0] tgt0 = target_of(eff_vol_a,
    eff_mute_a | force_mute);
  wire [`DVM_LVL_W-1:0] tgt1 = target_of(code_b, eff_mute_b | force_mute);
  wire [1:0] zc = {zero_cross_b, zero_cross_a};
  wire both_muted = (cur[0] == `DVM_LVL_MUTE) & (cur[1] == `DVM_LVL_MUTE);
  wire both_done = (cur[0] == tgt0) & (cur[1] == tgt1);
  // timeout only advances on frame ticks, so it counts samples
  wire [1:0] tmo_hit = {tick & (tmo[1] == TMO_LAST),
    tick & (tmo[0] == TMO_LAST)};
  wire [1:0] go = zc | tmo_hit;
  wire [2*`DVM_LVL_W-1:0] tgt_v = {tgt1, tgt0};
  wire imm_now = seq_imm | (eff_mode == `DVM_MODE_IMM);

  // one eighth-dB step toward the target
  function [`DVM_LVL_W-1:0] nudge;
    input [`DVM_LVL_W-1:0] from;
    input [`DVM_LVL_W-1:0] to;
    begin
      if (from < to)
        nudge = from + 10'h001;
      else
        nudge = from - 10'h001;
    end
  endfunction

  function [7:0] reg_read;
    input [7:0] idx;
    begin
      case (idx)
        `DVM_IDX_MIX: reg_read = mix_reg;
        `DVM_IDX_MUTE: reg_read = mute_reg;
        `DVM_IDX_VOL_A: reg_read = vol_a_reg;
        `DVM_IDX_VOL_B: reg_read = vol_b_reg;
        `DVM_IDX_RAMP: reg_read = ramp_reg;
        `DVM_IDX_MISC: reg_read = misc_reg;
        default: reg_read = 8'h00;
      endcase
    end
  endfunction

  // bus slave: zero wait states, OKAY always
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
      hreadyout <= 1'b0;
      hresp <= 1'b0;
      wr_pend <= 1'b0;
      wr_idx <= 8'h00;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (hready) begin
        wr_pend <= addr_ok & hwrite;
        wr_idx <= a_idx;
      end
      if (addr_ok & ~hwrite) begin
        if (a_idx == `DVM_IDX_STAT)
          hrdata <= {6'h00, cur[0], 13'h0000, seq_state != SQ_IDLE,
            silence_indicator_pin_b, silence_indicator_pin_a};
        else if (bus_wr && wr_idx == a_idx)
          // forward a write still in its data phase
          hrdata <= {24'h000000, hwdata[7:0]};
        else
          hrdata <= {24'h000000, reg_read(a_idx)};
      end
    end
  end

  // stored registers take writes even while frozen
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mix_reg <= `DVM_RST_MIX;
      mute_reg <= `DVM_RST_MUTE;
      vol_a_reg <= `DVM_RST_VOL;
      vol_b_reg <= `DVM_RST_VOL;
      ramp_reg <= `DVM_RST_RAMP;
      misc_reg <= `DVM_RST_MISC;
    end else if (bus_wr) begin
      case (wr_idx)
        `DVM_IDX_MIX: mix_reg <= wbyte & `DVM_MIX_MASK;
        `DVM_IDX_MUTE: mute_reg <= wbyte & `DVM_MUTE_MASK;
        `DVM_IDX_VOL_A: vol_a_reg <= wbyte;
        `DVM_IDX_VOL_B: vol_b_reg <= wbyte;
        `DVM_IDX_RAMP: ramp_reg <= wmerge(`DVM_RAMP_MASK, `DVM_RST_RAMP,
          wbyte);
        `DVM_IDX_MISC: misc_reg <= wbyte & `DVM_MISC_MASK;
        default: misc_reg <= misc_reg;
      endcase
    end
  end

  // applied copy updates only while not frozen
  // without host port, defaults rule the block
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      eff_vol_a <= `DVM_RST_VOL;
      eff_vol_b <= `DVM_RST_VOL;
      eff_mode <= RAMP_RST[`DVM_MODE_HI:`DVM_MODE_LO];
      eff_up <= 1'b1;
      eff_dn <= 1'b1;
      eff_filt <= 1'b0;
      eff_link <= 1'b0;
      eff_mute_a <= 1'b0;
      eff_mute_b <= 1'b0;
    end else if (!misc_reg[`DVM_HOST_PORT_ENABLE_BIT]) begin
      eff_vol_a <= `DVM_RST_VOL;
      eff_vol_b <= `DVM_RST_VOL;
      eff_mode <= RAMP_RST[`DVM_MODE_HI:`DVM_MODE_LO];
      eff_up <= 1'b1;
      eff_dn <= 1'b1;
      eff_filt <= 1'b0;
      eff_link <= 1'b0;
      eff_mute_a <= 1'b0;
      eff_mute_b <= 1'b0;
    end else if (apply) begin
      eff_vol_a <= vol_a_reg;
      eff_vol_b <= vol_b_reg;
      eff_mode <= ramp_reg[`DVM_MODE_HI:`DVM_MODE_LO];
      eff_up <= ramp_reg[`DVM_UP_BIT];
      eff_dn <= ramp_reg[`DVM_DN_BIT];
      eff_filt <= ramp_reg[`DVM_FILT_BIT];
      eff_link <= mix_reg[`DVM_LINK_BIT];
      eff_mute_a <= mute_reg[`DVM_MUTE_A_BIT];
      eff_mute_b <= mute_reg[`DVM_MUTE_B_BIT];
    end
  end

  // frame clock: a rising edge counts once the 2nd and 3rd stage agree
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fc_s1 <= 1'b0;
      fc_s2 <= 1'b0;
      fc_s3 <= 1'b0;
      fc_lvl <= 1'b0;
    end else begin
      fc_s1 <= frame_clock;
      fc_s2 <= fc_s1;
      fc_s3 <= fc_s2;
      if (fc_s2 == fc_s3)
        fc_lvl <= fc_s2;
    end
  end

  // filter swap and restart sequencer
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      seq_state <= SQ_IDLE;
      force_mute <= 1'b0;
      seq_imm <= 1'b0;
      rolloff_select <= 1'b0;
    end else begin
      case (seq_state)
        SQ_IDLE: begin
          if (mode_event) begin
            // restart after clock or mode change mutes at once
            force_mute <= 1'b1;
            seq_imm <= 1'b1;
            seq_state <= SQ_DOWN;
          end else if (eff_filt != rolloff_select) begin
            // gentle or immediate mute before swap
            force_mute <= 1'b1;
            seq_imm <= ~eff_dn;
            seq_state <= SQ_DOWN;
          end
        end
        SQ_DOWN: begin
          if (both_muted) begin
            rolloff_select <= eff_filt;
            force_mute <= 1'b0;
            seq_imm <= ~eff_up;
            seq_state <= SQ_UP;
          end
        end
        SQ_UP: begin
          if (both_done) begin
            seq_imm <= 1'b0;
            seq_state <= SQ_IDLE;
          end
        end
        default: seq_state <= SQ_IDLE;
      endcase
    end
  end

  // each channel has its own crossing and timeout
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (c = 0; c < 2; c = c + 1) begin
        cur[c] <= {`DVM_LVL_W{1'b0}};
        tmo[c] <= 10'h000;
      end
    end else begin
      for (c = 0; c < 2; c = c + 1) begin
        if (cur[c] == tgt_v[c*`DVM_LVL_W +: `DVM_LVL_W]) begin
          tmo[c] <= 10'h000;
        end else if (imm_now) begin
          cur[c] <= tgt_v[c*`DVM_LVL_W +: `DVM_LVL_W];
        end else if (eff_mode == `DVM_MODE_ZC) begin
          // whole change at crossing or timeout
          if (go[c]) begin
            cur[c] <= tgt_v[c*`DVM_LVL_W +: `DVM_LVL_W];
            tmo[c] <= 10'h000;
          end else if (tick) begin
            tmo[c] <= tmo[c] + 10'h001;
          end
        end else if (eff_mode == `DVM_MODE_SOFT) begin
          // one eighth dB each frame period
          if (tick)
            cur[c] <= nudge(cur[c], tgt_v[c*`DVM_LVL_W +: `DVM_LVL_W]);
        end else begin
          // eighth-dB step at crossing or timeout
          if (go[c]) begin
            cur[c] <= nudge(cur[c], tgt_v[c*`DVM_LVL_W +: `DVM_LVL_W]);
            tmo[c] <= 10'h000;
          end else if (tick) begin
            tmo[c] <= tmo[c] + 10'h001;
          end
        end
      end
    end
  end

  // outputs
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      level_a <= {`DVM_LVL_W{1'b0}};
      level_b <= {`DVM_LVL_W{1'b0}};
      silence_indicator_pin_a <= 1'b0;
      silence_indicator_pin_b <= 1'b0;
      low_power_state <= 1'b0;
      host_port_enable <= 1'b0;
    end else begin
      level_a <= cur[0];
      level_b <= cur[1];
      // indicator only once the level has reached silence
      silence_indicator_pin_a <= (eff_mute_a | force_mute) &
        (cur[0] == `DVM_LVL_MUTE);
      silence_indicator_pin_b <= (eff_mute_b | force_mute) &
        (cur[1] == `DVM_LVL_MUTE);
      low_power_state <= misc_reg[`DVM_PDN_BIT] & misc_reg[`DVM_HOST_PORT_ENABLE_BIT];
      host_port_enable <= misc_reg[`DVM_HOST_PORT_ENABLE_BIT];
    end
  end

endmodule

`default_nettype wire

// file: src/dvm_map.vh
/*
 * dvm_map.vh: register map, field positions, reset values and counts
 * of the level-control block. Assumes word-aligned AHB-Lite access,
 * byte address = 4 * register index.
 */
`ifndef DVM_MAP_VH
`define DVM_MAP_VH

// register indices
`define DVM_IDX_MIX 8'h03
`define DVM_IDX_MUTE 8'h04
`define DVM_IDX_VOL_A 8'h05
`define DVM_IDX_VOL_B 8'h06
`define DVM_IDX_RAMP 8'h07
`define DVM_IDX_MISC 8'h08
`define DVM_IDX_STAT 8'h09

// field positions
`define DVM_LINK_BIT 7
`define DVM_MUTE_A_BIT 4
`define DVM_MUTE_B_BIT 3
`define DVM_MODE_HI 7
`define DVM_MODE_LO 6
`define DVM_UP_BIT 5
`define DVM_DN_BIT 4
`define DVM_FILT_BIT 2
`define DVM_PDN_BIT 7
`define DVM_HOST_PORT_ENABLE_BIT 6
`define DVM_FREEZE_BIT 5

// writable bits and reset values
`define DVM_MIX_MASK 8'h80
`define DVM_MUTE_MASK 8'h18
`define DVM_RAMP_MASK 8'hf4
`define DVM_MISC_MASK 8'he0
`define DVM_RST_VOL 8'h00
`define DVM_RST_MIX 8'h00
`define DVM_RST_MUTE 8'h00
`define DVM_RST_RAMP 8'hb1
`define DVM_RST_MISC 8'h80

// transition modes
`define DVM_MODE_IMM 2'h0
`define DVM_MODE_ZC 2'h1
`define DVM_MODE_SOFT 2'h2
`define DVM_MODE_SOFTZC 2'h3

// levels in eighth-dB units; one half-dB code step is four units
`define DVM_LVL_W 10
`define DVM_LVL_MUTE 10'h3ff
// zero-cross timeout in sample periods, inside the 512..1024 window
`define DVM_ZC_TIMEOUT 10'h300

`endif

// file: verification/dvm_host.sv
/* dvm_host: host model, single-word AHB-Lite master.
   assumes one slave whose hreadyout is fed back as hready. */
`timescale 1ns/100ps
`default_nettype none
module dvm_host (
  // clock
  input wire logic hclk,
  // request
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  // answer
  input wire logic hready,
  input wire logic [31:0] hrdata
);
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end
  task xfer(input logic w, input logic [31:0] a, input logic [31:0] wd,
            output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
    // released data bus must not keep a stale value
    hwdata <= ~wd;
  endtask
endmodule
`default_nettype wire

// file: verification/dvm_level_ctrl_sva.sv
/* dvm_level_ctrl_sva: port checks of the level block.
   assumes one hclk domain; bound to every level block. */
`include "dvm_map.vh"
`timescale 1ns/100ps
`default_nettype none
module dvm_level_ctrl_sva (
  // bus
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // level side
  input wire logic mode_event,
  input wire logic [`DVM_LVL_W-1:0] level_a,
  input wire logic [`DVM_LVL_W-1:0] level_b,
  input wire logic silence_indicator_pin_a,
  input wire logic silence_indicator_pin_b,
  input wire logic rolloff_select,
  input wire logic low_power_state,
  input wire logic host_port_enable
);
  wire rd_take = hsel & htrans[1] & hready & ~hwrite;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  resp_okay_a: assert property (hresp == 1'b0)
    else $error("slave response not okay");
  ready_high_a: assert property ($past(hresetn) |-> hreadyout)
    else $error("slave inserted a wait state");
  rdata_hold_a: assert property (!$past(rd_take) |-> $stable(hrdata))
    else $error("read data moved without a read");
  power_gate_a: assert property (
    low_power_state |-> host_port_enable)
    else $error("low power while host port disabled");
  mute_ind_a: assert property (
    silence_indicator_pin_a |-> level_a == `DVM_LVL_MUTE)
    else $error("indicator a before level reached silence");
  ind_b_mute_a: assert property (
    silence_indicator_pin_b |-> level_b == `DVM_LVL_MUTE)
    else $error("indicator b before level reached silence");
  // level outputs lag the internal level by one edge, as does roll-off
  filt_after_mute_a: assert property (
    $changed(rolloff_select) && $past(host_port_enable) && host_port_enable
    |-> level_a == `DVM_LVL_MUTE && level_b == `DVM_LVL_MUTE)
    else $error("roll-off changed on an unsilenced output");
  mode_mute_a: assert property (
    mode_event && host_port_enable |-> ##[1:4] level_a == `DVM_LVL_MUTE)
    else $error("mode change did not silence channel a");
  cover property ($rose(silence_indicator_pin_a));
  cover property ($rose(low_power_state));
  cover property ($changed(rolloff_select));
endmodule
bind dvm_level_ctrl dvm_level_ctrl_sva chk (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .mode_event(mode_event), .level_a(level_a), .level_b(level_b),
  .silence_indicator_pin_a(silence_indicator_pin_a),
  .silence_indicator_pin_b(silence_indicator_pin_b),
  .rolloff_select(rolloff_select), .low_power_state(low_power_state),
  .host_port_enable(host_port_enable));
`default_nettype wire

// file: verification/test_dvm_level_ctrl.sv
/* test_dvm_level_ctrl: self-checking bench of the level block.
   assumes the host model and the bound checker. */
`include "dvm_map.vh"
`timescale 1ns/100ps
`default_nettype none
module test_dvm_level_ctrl;
  localparam logic [7:0] va = `DVM_IDX_VOL_A;
  localparam logic [7:0] vb = `DVM_IDX_VOL_B;
  localparam logic [7:0] rf = `DVM_IDX_RAMP;
  localparam logic [7:0] mc = `DVM_IDX_MISC;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic fclk = 1'b0;
  logic zca = 1'b0;
  logic zcb = 1'b0;
  logic mev = 1'b0;
  logic hsel, hwrite, hreadyout, hresp, sil_a, sil_b, roll, lowp, hpe;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [9:0] level_a, level_b;
  int error_cnt = 0;
  int checked = 0;
  int cyc = 0;
  int n;
  always #12.5 hclk = ~hclk;
  // sample clock: eight hclk periods, free running
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc % 4 == 3) fclk <= ~fclk;
    if (cyc == 20000) begin
      error_cnt = error_cnt + 1;
      tally_and_finish();
    end
  end
  dvm_host host (.hclk(hclk), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata));
  dvm_level_ctrl uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .frame_clock(fclk),
    .zero_cross_a(zca), .zero_cross_b(zcb), .mode_event(mev),
    .level_a(level_a), .level_b(level_b), .silence_indicator_pin_a(sil_a),
    .silence_indicator_pin_b(sil_b), .rolloff_select(roll),
    .low_power_state(lowp), .host_port_enable(hpe));
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  task wr(input logic [7:0] i, input logic [7:0] d);
    host.xfer(1'b1, {22'h0, i, 2'h0}, {24'h0, d}, rd);
  endtask
  task rdc(input string nm, input logic [7:0] i, input logic [7:0] e);
    host.xfer(1'b0, {22'h0, i, 2'h0}, 32'h0, rd);
    chk(nm, rd, {24'h0, e});
  endtask
  // bounded wait for channel a to reach a level
  task wl(input logic [9:0] e);
    n = 0;
    while (level_a !== e && n < 2000) begin
      @(negedge hclk);
      n++;
    end
  endtask
  task wn(input int k);
    repeat (k) @(negedge hclk);
  endtask
  task t_reset;
    rdc("vol_a", va, 8'h00);
    rdc("vol_b", vb, 8'h00);
    rdc("ramp", rf, 8'hb1);
    rdc("misc", mc, 8'h80);
    rdc("unmapped", 8'h0f, 8'h00);
    chk("port_en", hpe, 0);
    chk("low_pwr", lowp, 0);
    chk("roll_rst", roll, 0);
  endtask
  task t_imm;
    wr(mc, 8'h40);
    wr(rf, 8'h30);
    wr(va, 8'h06);
    wl(10'd24);
    chk("imm_step", n <= 4, 1);
    wr(`DVM_IDX_MUTE, 8'h10);
    wl(10'h3ff);
    chk("mute_a", n <= 4, 1);
    wn(2);
    chk("ind_a", sil_a, 1);
    chk("ind_b", sil_b, 0);
    wr(`DVM_IDX_MUTE, 8'h00);
    wl(10'd24);
    chk("unmute_a", level_a, 24);
    wr(`DVM_IDX_MIX, 8'h80);
    wn(4);
    chk("link_b", level_b, 24);
    wr(`DVM_IDX_MIX, 8'h00);
    wn(4);
    chk("unlink_b", level_b, 0);
  endtask
  task t_freeze;
    wr(mc, 8'h60);
    wr(va, 8'h0a);
    wr(vb, 8'h02);
    wn(8);
    chk("frozen_a", level_a, 24);
    wr(mc, 8'h40);
    wn(4);
    chk("thaw_a", level_a, 40);
    chk("thaw_b", level_b, 8);
  endtask
  task t_zc;
    wr(rf, 8'h70);
    wr(va, 8'h08);
    wn(20);
    chk("zc_wait", level_a, 40);
    @(posedge hclk) zcb <= 1'b1;
    @(posedge hclk) zcb <= 1'b0;
    wn(4);
    chk("zc_other", level_a, 40);
    @(posedge hclk) zca <= 1'b1;
    @(posedge hclk) zca <= 1'b0;
    wn(4);
    chk("zc_hit", level_a, 32);
  endtask
  task t_soft;
    wr(rf, 8'hb0);
    wr(va, 8'h09);
    wl(10'd36);
    chk("soft_rate", n >= 24 && n <= 48, 1);
    @(posedge hclk) mev <= 1'b1;
    @(posedge hclk) mev <= 1'b0;
    wn(3);
    chk("mode_mute", level_a >= 10'h3f8, 1);
  endtask
  task t_filt;
    wr(rf, 8'h34);
    n = 0;
    while (roll !== 1'b1 && n < 200) begin
      @(negedge hclk);
      n++;
    end
    chk("rolloff", roll, 1);
    rdc("ramp_rb", rf, 8'h35);
  endtask
  // roll-off stays slow so no filter swap starts here
  task t_szc;
    wr(rf, 8'hf4);
    wr(va, 8'h07);
    wn(20);
    chk("szc_wait", level_a, 36);
    @(posedge hclk) zca <= 1'b1;
    @(posedge hclk) zca <= 1'b0;
    wn(4);
    chk("szc_step", level_a, 35);
    // no crossing: step forced within 512..1024 frame periods
    n = 0;
    while (level_a !== 10'd34 && n < 9000) begin
      @(negedge hclk);
      n++;
    end
    chk("szc_tmo", n >= 4096 && n <= 8192, 1);
  endtask
  task t_power;
    wr(mc, 8'hc0);
    wn(3);
    chk("low_pwr_on", lowp, 1);
    rdc("vol_kept", va, 8'h07);
    wr(mc, 8'h80);
    wn(3);
    chk("pdn_ignored", lowp, 0);
    chk("port_off", hpe, 0);
  endtask
  task tally_and_finish;
    if (error_cnt == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    t_reset();
    t_imm();
    t_freeze();
    t_zc();
    t_soft();
    t_filt();
    t_szc();
    t_power();
    tally_and_finish();
  end
endmodule
`default_nettype wire
